// File: erb_defs.vh
`ifndef ERB_DEFS_VH
`define ERB_DEFS_VH

// Array shape: 4096 bits held as 256 rows of 16 bits
`define ERB_ROWS        256
`define ERB_ROW_W       16
`define ERB_ROW_AW      8
`define ERB_ADDR_W      11

// Operating modes
`define ERB_MODE_SINGLE 2'h0
`define ERB_MODE_DUAL   2'h1
`define ERB_MODE_ROM    2'h2

// Geometry codes: shift of the address above the row index
`define ERB_GEOM_256X16 2'h0
`define ERB_GEOM_512X8  2'h1
`define ERB_GEOM_1KX4   2'h2
`define ERB_GEOM_2KX2   2'h3

// Clocking schemes
`define ERB_SCHEME_WR_RD 1'h0
`define ERB_SCHEME_IN_OUT 1'h1

// Register-or-bypass select bits (1 = bypass)
`define ERB_BYP_W       6
`define ERB_BYP_WDATA   0
`define ERB_BYP_DOUT    1
`define ERB_BYP_WADDR   2
`define ERB_BYP_WE      3
`define ERB_BYP_RADDR   4
`define ERB_BYP_RE      5

// Reset values
`define ERB_ZERO_DATA   16'h0000
`define ERB_ZERO_ADDR   11'h000

`endif

// File: erb_embedded_ram_block.v
`timescale 1ns/10ps
`include "erb_defs.vh"
// Notes on behaviour
// [RULE1] Four geometries: 256x16, 512x8, 1Kx4, 2Kx2
// [RULE2] Single-port or dual-port mode by configuration
// [RULE3] Write and read sections run separate clocks
// [RULE4] Each section has own synchronous clock enable
// [RULE5] Alternative: input registers and output registers clocked apart
// [RULE6] Each listed path registered or bypassed individually
// [RULE7] All registers cleared by local, global, reset
// [RULE8] Writes synchronous, strobe made internally from clock
// [RULE9] Wider memories: user places blocks side by side
// [RULE10] Deeper memories: user cascades by upper address
// [RULE11] Lookup mode: preloaded read-only, 8 in 16 out
// [RULE12] True two-port access needs two blocks
// [RULE13] Capacity fixed at 4096 bits every geometry
// [RULE14] Address width follows depth; upper bits ignored
// [RULE15] Same-address read during write returns old word

module erb_embedded_ram_block (
  // Clock, reset, global clock enable
  input  wire                     CORE_CLK_IN,
  input  wire                     RESET_IN,
  input  wire                     CE_IN,
  // Extra asynchronous clears
  input  wire                     LOCAL_CLR_IN,
  input  wire                     GLOBAL_CLR_IN,
  // Configuration
  input  wire [1:0]               MODE_IN,
  input  wire [1:0]               GEOM_IN,
  input  wire                     SCHEME_IN,
  input  wire [`ERB_BYP_W-1:0]    BYPASS_IN,
  // Preload port
  input  wire                     CFG_WR_IN,
  input  wire [`ERB_ROW_AW-1:0]   CFG_ADDR_IN,
  input  wire [`ERB_ROW_W-1:0]    CFG_DATA_IN,
  // Section A tick and enable
  input  wire                     SEC_A_TICK_IN,
  input  wire                     SEC_A_CE_IN,
  // Section B tick and enable
  input  wire                     SEC_B_TICK_IN,
  input  wire                     SEC_B_CE_IN,
  // Write side
  input  wire [`ERB_ADDR_W-1:0]   WR_ADDR_IN,
  input  wire [`ERB_ROW_W-1:0]    WR_DATA_IN,
  input  wire                     WR_EN_IN,
  // Read side
  input  wire [`ERB_ADDR_W-1:0]   RD_ADDR_IN,
  input  wire                     RD_EN_IN,
  // Read result
  output reg  [`ERB_ROW_W-1:0]    RD_DATA_OUT,
  output reg                      RD_VALID_OUT
);

  reg  [`ERB_ROW_W-1:0]  mem [0:`ERB_ROWS-1];
  reg  [`ERB_ROW_W-1:0]  wdata_q;
  reg  [`ERB_ADDR_W-1:0] waddr_q;
  reg                    we_q;
  reg  [`ERB_ADDR_W-1:0] raddr_q;
  reg                    re_q;
  reg  [`ERB_ROW_W-1:0]  rd_word;
  reg                    rd_word_vld;

  wire clr = RESET_IN | LOCAL_CLR_IN | GLOBAL_CLR_IN; // [RULE7]

  wire is_rom  = (MODE_IN == `ERB_MODE_ROM);
  wire is_dual = (MODE_IN == `ERB_MODE_DUAL);
  // Lookup mode reads whole 16-bit rows by an 8-bit address
  wire [1:0] geom = is_rom ? `ERB_GEOM_256X16 : GEOM_IN; // [RULE11] [RULE1]

  // Section ticks, each gated by its own enable
  wire a_go  = CE_IN & SEC_A_TICK_IN & SEC_A_CE_IN; // [RULE4]
  wire b_go  = CE_IN & SEC_B_TICK_IN & SEC_B_CE_IN; // [RULE4]
  // Read input stage: read section, or input side in the in/out scheme
  wire rd_go = (SCHEME_IN == `ERB_SCHEME_IN_OUT) ? a_go : b_go; // [RULE3] [RULE5]
  wire wr_go = a_go; // [RULE3]
  wire out_go = b_go; // [RULE5]

  ////////////////////////////////////////////////////////////////////////////
  // Effective controls after register-or-bypass selection

  wire [`ERB_ROW_W-1:0]  eff_wdata = BYPASS_IN[`ERB_BYP_WDATA] ? WR_DATA_IN : wdata_q; // [RULE6]
  wire [`ERB_ADDR_W-1:0] eff_waddr = BYPASS_IN[`ERB_BYP_WADDR] ? WR_ADDR_IN : waddr_q; // [RULE6]
  wire                   eff_we    = BYPASS_IN[`ERB_BYP_WE] ? WR_EN_IN : we_q; // [RULE6]
  wire [`ERB_ADDR_W-1:0] rd_sel    = BYPASS_IN[`ERB_BYP_RADDR] ? RD_ADDR_IN : raddr_q; // [RULE6]
  wire                   eff_re    = BYPASS_IN[`ERB_BYP_RE] ? RD_EN_IN : re_q; // [RULE6]
  // Single-port mode shares the write address for reads
  wire [`ERB_ADDR_W-1:0] eff_raddr = is_dual | is_rom ? rd_sel : eff_waddr; // [RULE2]

  ////////////////////////////////////////////////////////////////////////////
  // Geometry mapping onto the fixed 256x16 array

  // Row index: address bits above the lane bits; upper bits ignored
  function [`ERB_ROW_AW-1:0] row_of;
    input [`ERB_ADDR_W-1:0] a;
    input [1:0]             g;
    begin
      row_of = a[`ERB_ROW_AW-1:0];
      case (g)
        `ERB_GEOM_512X8: row_of = a[8:1]; // [RULE14]
        `ERB_GEOM_1KX4:  row_of = a[9:2]; // [RULE14]
        `ERB_GEOM_2KX2:  row_of = a[10:3]; // [RULE14]
        default:         row_of = a[7:0]; // [RULE14]
      endcase
    end
  endfunction

  // Lane mask within the row, narrow word in low lane bits
  function [`ERB_ROW_W-1:0] lane_mask;
    input [`ERB_ADDR_W-1:0] a;
    input [1:0]             g;
    begin
      lane_mask = 16'hFFFF;
      case (g)
        `ERB_GEOM_512X8: lane_mask = 16'h00FF << {a[0], 3'h0};
        `ERB_GEOM_1KX4:  lane_mask = 16'h000F << {a[1:0], 2'h0};
        `ERB_GEOM_2KX2:  lane_mask = 16'h0003 << {a[2:0], 1'h0};
        default:         lane_mask = 16'hFFFF;
      endcase
    end
  endfunction

  // Bit offset of the addressed lane
  function [3:0] lane_shift;
    input [`ERB_ADDR_W-1:0] a;
    input [1:0]             g;
    begin
      lane_shift = 4'h0;
      case (g)
        `ERB_GEOM_512X8: lane_shift = {a[0], 3'h0};
        `ERB_GEOM_1KX4:  lane_shift = {a[1:0], 2'h0};
        `ERB_GEOM_2KX2:  lane_shift = {a[2:0], 1'h0};
        default:         lane_shift = 4'h0;
      endcase
    end
  endfunction

  // Width of the word in bits, as a mask of the low lane
  function [`ERB_ROW_W-1:0] width_mask;
    input [1:0] g;
    begin
      width_mask = 16'hFFFF;
      case (g)
        `ERB_GEOM_512X8: width_mask = 16'h00FF;
        `ERB_GEOM_1KX4:  width_mask = 16'h000F;
        `ERB_GEOM_2KX2:  width_mask = 16'h0003;
        default:         width_mask = 16'hFFFF;
      endcase
    end
  endfunction

  wire [`ERB_ROW_AW-1:0] w_row   = row_of(eff_waddr, geom); // [RULE13]
  wire [`ERB_ROW_W-1:0]  w_mask  = lane_mask(eff_waddr, geom);
  wire [3:0]             w_shift = lane_shift(eff_waddr, geom);
  wire [`ERB_ROW_W-1:0]  w_word  = (eff_wdata & width_mask(geom)) << w_shift;

  wire [`ERB_ROW_AW-1:0] r_row   = row_of(eff_raddr, geom); // [RULE13]
  wire [3:0]             r_shift = lane_shift(eff_raddr, geom);
  wire [`ERB_ROW_W-1:0]  r_word  = (mem[r_row] >> r_shift) & width_mask(geom);

  // Internal write strobe from the write tick; lookup mode is read-only
  wire do_write = wr_go & eff_we & ~is_rom; // [RULE8] [RULE11]
  wire do_read  = rd_go & eff_re;

  ////////////////////////////////////////////////////////////////////////////
  // Storage array: preload port first, then user writes

  always @(posedge CORE_CLK_IN) begin
    if (CE_IN & CFG_WR_IN) begin
      mem[CFG_ADDR_IN] <= CFG_DATA_IN; // [RULE11]
    end else if (do_write) begin
      mem[w_row] <= (mem[w_row] & ~w_mask) | (w_word & w_mask); // [RULE8]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write-section input registers

  always @(posedge CORE_CLK_IN or posedge clr) begin
    if (clr) begin
      wdata_q <= `ERB_ZERO_DATA; // [RULE7]
      waddr_q <= `ERB_ZERO_ADDR;
      we_q    <= 1'b0;
    end else if (wr_go) begin
      wdata_q <= WR_DATA_IN; // [RULE6]
      waddr_q <= WR_ADDR_IN;
      we_q    <= WR_EN_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-section input registers

  always @(posedge CORE_CLK_IN or posedge clr) begin
    if (clr) begin
      raddr_q <= `ERB_ZERO_ADDR; // [RULE7]
      re_q    <= 1'b0;
    end else if (rd_go) begin
      raddr_q <= RD_ADDR_IN; // [RULE6]
      re_q    <= RD_EN_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array read and output register

  // Array read samples the old word, so a same-cycle write is not seen
  always @(posedge CORE_CLK_IN or posedge clr) begin
    if (clr) begin
      rd_word     <= `ERB_ZERO_DATA; // [RULE7]
      rd_word_vld <= 1'b0;
    end else if (do_read) begin
      rd_word     <= r_word; // [RULE15]
      rd_word_vld <= 1'b1;
    end
  end

  always @(posedge CORE_CLK_IN or posedge clr) begin
    if (clr) begin
      RD_DATA_OUT  <= `ERB_ZERO_DATA; // [RULE7]
      RD_VALID_OUT <= 1'b0;
    end else if (BYPASS_IN[`ERB_BYP_DOUT]) begin
      // Bypassed output follows the array read directly
      if (do_read) begin
        RD_DATA_OUT  <= r_word; // [RULE6] [RULE15]
        RD_VALID_OUT <= 1'b1;
      end
    end else if (out_go) begin
      RD_DATA_OUT  <= rd_word; // [RULE5] [RULE6]
      RD_VALID_OUT <= rd_word_vld;
    end
  end

endmodule // erb_embedded_ram_block

// File: erb_pad.v
`timescale 1ns/10ps

// File: erb_user_model.sv
`timescale 1ns/10ps
module erb_user_model (
  // Clock and pace select
  input  wire  clk_in,
  input  wire  slow_in,
  // Section ticks
  output logic a_tick_out = 1'b1,
  output logic b_tick_out = 1'b1
);
  logic ph = 1'b0;
  // One write and one read per edge on each block; two-way traffic uses two blocks
  // Every block sees the full address; no upper-bit cascade select needed here
  // Write side every cycle, read side every other cycle when slow
  always @(negedge clk_in) begin
    ph <= ~ph;
    a_tick_out <= 1'b1;
    b_tick_out <= ~slow_in | ph;
  end
endmodule // erb_user_model

// File: erb_properties.sv
`timescale 1ns/10ps
module erb_properties (
  input wire CORE_CLK_IN, RESET_IN, CE_IN, LOCAL_CLR_IN, GLOBAL_CLR_IN, SCHEME_IN, RD_EN_IN,
  input wire SEC_A_TICK_IN, SEC_A_CE_IN, SEC_B_TICK_IN, SEC_B_CE_IN, RD_VALID_OUT,
  input wire [1:0]  MODE_IN, GEOM_IN,
  input wire [5:0]  BYPASS_IN,
  input wire [15:0] RD_DATA_OUT
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (RESET_IN | LOCAL_CLR_IN | GLOBAL_CLR_IN);
  wire byp = BYPASS_IN == 6'h3F;
  wire sec = SCHEME_IN ? SEC_A_TICK_IN & SEC_A_CE_IN : SEC_B_TICK_IN & SEC_B_CE_IN;
  wire rd_now = CE_IN & byp & RD_EN_IN & sec;
  ////////////////////////////////////////////////////////////////////////////
  AST_RESET_CLR: assert property (disable iff (1'b0) RESET_IN && $past(RESET_IN) |-> RD_DATA_OUT == 16'h0000 && !RD_VALID_OUT)
    else $error("Outputs not cleared by reset");
  AST_EXTRA_CLR: assert property (disable iff (1'b0) (LOCAL_CLR_IN | GLOBAL_CLR_IN) |-> RD_DATA_OUT == 16'h0000 && !RD_VALID_OUT)
    else $error("Outputs not cleared by extra clear");
  AST_CE_FREEZE: assert property (!CE_IN |=> $stable(RD_DATA_OUT) && $stable(RD_VALID_OUT))
    else $error("Output moved with clock enable low");
  AST_NO_READ_HOLD: assert property (byp && !RD_EN_IN |=> $stable(RD_DATA_OUT))
    else $error("Output moved without a read");
  AST_VALID_STICKY: assert property (RD_VALID_OUT |=> RD_VALID_OUT)
    else $error("Valid dropped");
  AST_READ_VALID: assert property (rd_now |=> RD_VALID_OUT)
    else $error("Valid not set one edge after read");
  AST_B_CE_HOLD: assert property (byp && !SCHEME_IN && !SEC_B_CE_IN |=> $stable(RD_DATA_OUT))
    else $error("Read section acted with its enable low");
  AST_OUTREG_B: assert property (SCHEME_IN && !BYPASS_IN[1] && !SEC_B_TICK_IN |=> $stable(RD_DATA_OUT))
    else $error("Output register moved without its tick");
  AST_NARROW: assert property (rd_now && GEOM_IN == 2'h3 && MODE_IN != 2'h2 |=> RD_DATA_OUT[15:2] == 14'h0000)
    else $error("Upper bits set in 2-bit geometry");
  cover property (rd_now && GEOM_IN == 2'h3);
  cover property (SCHEME_IN && RD_EN_IN && !BYPASS_IN[1]);
  cover property (rd_now && MODE_IN == 2'h2);
endmodule // erb_properties
bind erb_embedded_ram_block erb_properties u_props (.*);

// File: erb_embedded_ram_block_tb_top.sv
`timescale 1ns/10ps
`include "erb_defs.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module erb_embedded_ram_block_tb_top;
  logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, lclr = 1'b0, gclr = 1'b0, slow = 1'b0;
  logic [1:0]  mode = `ERB_MODE_DUAL, geom = `ERB_GEOM_256X16;
  logic        scheme = `ERB_SCHEME_WR_RD, cfg_wr = 1'b0, a_ce = 1'b1, b_ce = 1'b1;
  logic        we = 1'b0, re = 1'b0, a_tick, b_tick, valid;
  logic [5:0]  byp = 6'h3F;
  logic [7:0]  cfg_addr = 8'h00;
  logic [15:0] cfg_data = 16'h0000, wdata = 16'h0000, rdata, rdata_hi, exp;
  logic [10:0] addr = 11'h000;
  int          failures = 0, check_count = 0, cycles = 0, g;
  erb_embedded_ram_block dut (.CORE_CLK_IN(clk), .RESET_IN(rst), .CE_IN(ce), .LOCAL_CLR_IN(lclr),
    .GLOBAL_CLR_IN(gclr), .MODE_IN(mode), .GEOM_IN(geom), .SCHEME_IN(scheme), .BYPASS_IN(byp),
    .CFG_WR_IN(cfg_wr), .CFG_ADDR_IN(cfg_addr), .CFG_DATA_IN(cfg_data), .SEC_A_TICK_IN(a_tick),
    .SEC_A_CE_IN(a_ce), .SEC_B_TICK_IN(b_tick), .SEC_B_CE_IN(b_ce), .WR_ADDR_IN(addr),
    .WR_DATA_IN(wdata), .WR_EN_IN(we), .RD_ADDR_IN(addr), .RD_EN_IN(re), .RD_DATA_OUT(rdata),
    .RD_VALID_OUT(valid));
  // Second block side by side, sharing address and control, holds the upper half
  erb_embedded_ram_block wide (.CORE_CLK_IN(clk), .RESET_IN(rst), .CE_IN(ce), .LOCAL_CLR_IN(lclr),
    .GLOBAL_CLR_IN(gclr), .MODE_IN(mode), .GEOM_IN(geom), .SCHEME_IN(scheme), .BYPASS_IN(byp),
    .CFG_WR_IN(cfg_wr), .CFG_ADDR_IN(cfg_addr), .CFG_DATA_IN(cfg_data), .SEC_A_TICK_IN(a_tick),
    .SEC_A_CE_IN(a_ce), .SEC_B_TICK_IN(b_tick), .SEC_B_CE_IN(b_ce), .WR_ADDR_IN(addr),
    .WR_DATA_IN(~wdata), .WR_EN_IN(we), .RD_ADDR_IN(addr), .RD_EN_IN(re), .RD_DATA_OUT(rdata_hi),
    .RD_VALID_OUT());
  erb_user_model far (.clk_in(clk), .slow_in(slow), .a_tick_out(a_tick), .b_tick_out(b_tick));
  initial forever #50 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (failures == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      final_report();
    end
  end
  // Waits for an edge where the chosen section acts
  task automatic go(input logic sec_b);
    int n = 0;
    do begin @(posedge clk); n++; end while (!(sec_b ? b_tick : a_tick) && n < 8);
  endtask
  // Holds one request over the given count of acting edges
  task automatic acc(input logic w, r, input logic [10:0] a, input logic [15:0] d, input int hold);
    @(negedge clk); we = w; re = r; addr = a; wdata = d;
    repeat (hold) go(r && !scheme);
    @(negedge clk); we = 1'b0; re = 1'b0;
  endtask
  task automatic rd(input logic [10:0] a, input logic [15:0] e, input int hold);
    acc(1'b0, 1'b1, a, 16'h0000, hold);
    `CHK("read data", e, rdata)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk); rst = 1'b0;
    `CHK("valid after reset", 1'b0, valid)
    `CHK("data after reset", 16'h0000, rdata)
    // Two lanes of one row per narrow geometry, one word twice in 256x16; unused upper address bit set on read except in 2Kx2
    for (g = 0; g < 4; g++) begin
      geom = g[1:0];
      acc(1'b1, 1'b0, 11'h012 << g, 16'hA5C3, 1);
      acc(1'b1, 1'b0, (11'h012 << g) | ((11'h001 << g) - 11'h001), 16'h3C5A, 1);
      exp = (g == 0) ? 16'h3C5A : 16'hA5C3 & ((16'h0001 << (16 >> g)) - 16'h0001);
      rd((11'h012 << g) | ((g < 3) ? 11'h400 : 11'h000), exp, 1);
    end
    geom = `ERB_GEOM_256X16;
    acc(1'b1, 1'b0, 11'h033, 16'h1111, 1);
    acc(1'b1, 1'b1, 11'h033, 16'h2222, 1);
    `CHK("read during write", 16'h1111, rdata)
    rd(11'h033, 16'h2222, 1);
    `CHK("wide upper half", 16'hDDDD, rdata_hi)
    b_ce = 1'b0;
    rd(11'h012, 16'h2222, 1);
    b_ce = 1'b1; ce = 1'b0;
    acc(1'b1, 1'b0, 11'h033, 16'h3333, 1);
    ce = 1'b1;
    rd(11'h033, 16'h2222, 1);
    slow = 1'b1;
    acc(1'b1, 1'b0, 11'h044, 16'h4444, 1);
    rd(11'h044, 16'h4444, 1);
    slow = 1'b0; mode = `ERB_MODE_SINGLE;
    acc(1'b1, 1'b0, 11'h055, 16'h5555, 1);
    rd(11'h055, 16'h5555, 1);
    mode = `ERB_MODE_DUAL;
    // Each path registered alone
    for (g = 0; g < 6; g++) begin
      byp = 6'h3F ^ (6'h01 << g);
      acc(1'b1, 1'b0, 11'h070, {12'h0F0, g[3:0]}, 2);
      rd(11'h070, {12'h0F0, g[3:0]}, 4);
    end
    scheme = `ERB_SCHEME_IN_OUT; byp = 6'h00;
    acc(1'b1, 1'b0, 11'h066, 16'h6666, 2);
    rd(11'h066, 16'h6666, 4);
    scheme = `ERB_SCHEME_WR_RD; byp = 6'h3F; lclr = 1'b1;
    @(negedge clk); `CHK("local clear", 16'h0000, rdata)
    lclr = 1'b0; gclr = 1'b1;
    @(negedge clk); `CHK("global clear", 1'b0, valid)
    gclr = 1'b0; mode = `ERB_MODE_ROM; cfg_addr = 8'h07; cfg_data = 16'hBEEF; cfg_wr = 1'b1;
    @(negedge clk); cfg_wr = 1'b0;
    acc(1'b1, 1'b0, 11'h007, 16'h1234, 1);
    rd(11'h007, 16'hBEEF, 1);
    final_report();
  end
endmodule // erb_embedded_ram_block_tb_top
